// *** hdl/cwr_regs.svh ***
// constants for the cache way retirement and translation error recovery block
// assumes inclusion by the counter, checker and recovery design files of the block
`ifndef CWR_REGS_SVH
`define CWR_REGS_SVH
`define CWR_L1_WAYS 4
`define CWR_L2_WAYS 8
`define CWR_ERR_THRESHOLD 4
`define CWR_INTERVAL_US 100
`define CWR_CLK_MHZ 250
`define CWR_INTERVAL_CYCLES (`CWR_INTERVAL_US * `CWR_CLK_MHZ)
`define CWR_CNT_W 8
`define CWR_FS_L1_DG 0
`define CWR_FS_L2_DG 1
`define CWR_UG_DX 0
`define CWR_UG_IX 1
`endif

// *** hdl/cwr_pkg.sv ***
// types shared by the error recovery block and its leaves
// assumes nothing beyond a SystemVerilog compiler
package cwr_pkg;
    typedef enum logic [1:0] {
        CWR_SRC_L1,
        CWR_SRC_L2
    } cwr_src_e;
    // one translation buffer lookup result with both copies of a fully associative entry
    typedef struct packed {
        logic valid;
        logic is_instr;
        logic is_fully;
        logic direct_port;
        logic [5:0] index;
        logic par_err_a;
        logic par_err_b;
        logic [2:0] lock_copies;
    } cwr_xlate_s;
endpackage

// *** hdl/cwr_way_counter.sv ***
// per-way error counter with threshold detect inside a fixed interval
// assumes err pulses and interval_end come from the core clock domain
`timescale 1ns/1ps
`include "cwr_regs.svh"
module cwr_way_counter
    import cwr_pkg::*;
#(
    parameter int WIDTH = `CWR_CNT_W,
    parameter int THRESHOLD = `CWR_ERR_THRESHOLD
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic err,
    input wire logic interval_end,
    output logic over
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic over;
    } cwr_cnt_s;
    cwr_cnt_s state;
    cwr_cnt_s next_state;

    // count saturates so a storm of errors cannot wrap below the threshold
    always_comb
    begin
        next_state = state;
        next_state.over = 1'b0;
        // an error on the restart cycle opens the new interval instead of being lost
        if (interval_end)
            next_state.count = err ? WIDTH'(1) : '0;
        else if (err && state.count != {WIDTH{1'b1}})
            next_state.count = state.count + 1'b1;
        if (err && !interval_end && state.count >= WIDTH'(THRESHOLD))
            next_state.over = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            state <= '0;
        else
            state <= next_state;
    end
    assign over = state.over;
endmodule

// *** hdl/cwr_xlate_check.sv ***
// translation buffer entry error classifier
// assumes one lookup result per cycle from the translation pipeline
`timescale 1ns/1ps
`include "cwr_regs.svh"
module cwr_xlate_check
    import cwr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input cwr_xlate_s look,
    output logic inval,
    output logic repair_a,
    output logic repair_b,
    output logic fatal,
    output logic urg_data,
    output logic urg_instr,
    output logic lock
);
    typedef struct packed {
        logic inval;
        logic repair_a;
        logic repair_b;
        logic fatal;
        logic urg_data;
        logic urg_instr;
        logic lock;
    } cwr_xc_s;
    cwr_xc_s state;
    cwr_xc_s next_state;

    function automatic logic vote3(input logic [2:0] v);
        vote3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    // direct port reads report, translation lookups invalidate or repair silently, or go fatal when both copies fail
    always_comb
    begin
        logic any_err;
        any_err = 1'b0;
        next_state = '0;
        any_err = look.par_err_a | (look.is_fully & look.par_err_b);
        next_state.lock = look.is_fully & vote3(look.lock_copies);
        if (look.valid && look.direct_port && look.par_err_a)
        begin
            next_state.urg_data = !look.is_instr;
            next_state.urg_instr = look.is_instr;
        end
        else if (look.valid && any_err)
        begin
            if (!look.is_fully)
                next_state.inval = 1'b1;
            else if (look.par_err_a && look.par_err_b)
                next_state.fatal = 1'b1;
            else
            begin
                next_state.repair_a = look.par_err_a;
                next_state.repair_b = look.par_err_b;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            state <= '0;
        else
            state <= next_state;
    end
    assign inval = state.inval;
    assign repair_a = state.repair_a;
    assign repair_b = state.repair_b;
    assign fatal = state.fatal;
    assign urg_data = state.urg_data;
    assign urg_instr = state.urg_instr;
    assign lock = state.lock;
endmodule

// *** hdl/cwr_recovery.sv ***
// cache way retirement and translation buffer error recovery
// assumes the load/store pipeline and the second level cache carry out the
// requested writebacks and invalidations and answer with done pulses
// only one retirement runs at a time, so a second level reduction held back
// by the hold bit also holds back later first level retirements
// errors on a retired way are no longer counted
// restrainable, urgent and fatal reports leave as one-cycle pulses
// Notes on behaviour
// - with one data way already retired, only the failing entry is written back then invalidated.
// - with no data way retired, the failing way is flushed with writeback of dirty lines and never refilled.
// - retiring a data way sets the level one degrade flag and raises a restrainable error.
// - second level reduction waits while the reduction hold bit is set and starts once it clears.
// - with one second level way left, all its entries are invalidated but it stays usable, flag and error follow.
// - otherwise every second level way is invalidated and the failing way is disabled, flag and error follow.
// - translation tags and data carry parity, and the fully associative lock bit is a vote of three copies.
// - translation entries are checked both in lookups and in direct tag or data port reads.
// - an error seen through the data translation ports sets the data urgent flag and an urgent error.
// - an error seen through the instruction translation ports sets the instruction urgent flag and an urgent error.
// - a set associative entry error during lookup invalidates the entry silently.
// - a fully associative error in one copy is repaired from the other copy silently.
// - errors in both fully associative copies raise a fatal error.
// - each way of each cache has its own error counter.
// - a way is retired when its counter passes the threshold inside the interval.
`timescale 1ns/1ps
`include "cwr_regs.svh"
module cwr_recovery
    import cwr_pkg::*;
#(
    parameter int L1_WAYS = `CWR_L1_WAYS,
    parameter int L2_WAYS = `CWR_L2_WAYS,
    parameter int THRESHOLD = `CWR_ERR_THRESHOLD,
    parameter int INTERVAL_CYCLES = `CWR_INTERVAL_CYCLES
)
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [L1_WAYS-1:0] L1_ERR,
    input wire logic [L2_WAYS-1:0] L2_ERR,
    input wire logic L2_REDUCTION_HOLD,
    input wire logic ASYNC_FAULT_CLEAR,
    input wire logic URGENT_CLEAR,
    input cwr_xlate_s XLATE_LOOK,
    input wire logic OP_DONE,
    output logic L1_ENTRY_FLUSH,
    output logic L1_WAY_FLUSH,
    output logic [L1_WAYS-1:0] L1_OP_WAY,
    output logic [L1_WAYS-1:0] L1_WAY_DISABLE,
    output logic L2_FLUSH_ALL,
    output logic [L2_WAYS-1:0] L2_OP_WAY,
    output logic [L2_WAYS-1:0] L2_WAY_DISABLE,
    output logic L1_WAY_DEGRADED_FLAG,
    output logic L2_WAY_DEGRADED_FLAG,
    output logic RESTRAINABLE_ERR,
    output logic DATA_XLATE_URGENT_FLAG,
    output logic INSTR_XLATE_URGENT_FLAG,
    output logic INSTR_URGENT_ERR,
    output logic FATAL_ERR,
    output logic XLATE_INVAL,
    output logic XLATE_REPAIR_A,
    output logic XLATE_REPAIR_B,
    output logic XLATE_LOCK
);
    // sequencer states; the three flush states hold their request until done
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_L1_ENTRY,
        ST_L1_WAY,
        ST_L2_WAIT,
        ST_L2_FLUSH,
        ST_DONE
    } cwr_state_e;

    // every register of this module lives in this one struct; the counters and the checker keep their own
    typedef struct packed {
        cwr_state_e fsm;
        cwr_src_e src;
        logic [L1_WAYS-1:0] l1_op;
        logic [L1_WAYS-1:0] l1_dis;
        logic [L2_WAYS-1:0] l2_op;
        logic [L2_WAYS-1:0] l2_dis;
        logic l2_keep;
        logic [L2_WAYS-1:0] l2_pend;
        logic [L1_WAYS-1:0] l1_pend;
        logic l1_dg;
        logic l2_dg;
        logic restr;
        logic urg_d;
        logic urg_i;
        logic urg_err;
        logic [31:0] tick;
        logic tick_end;
    } cwr_top_s;

    cwr_top_s state;
    cwr_top_s next_state;

    // threshold pulses from the counters, urgent pulses from the checker
    logic [L1_WAYS-1:0] l1_over;
    logic [L2_WAYS-1:0] l2_over;
    logic xc_urg_d;
    logic xc_urg_i;

    // lowest set bit as one-hot, used for both caches
    function automatic logic [15:0] first_one(input logic [15:0] v);
        first_one = v & (~v + 16'h0001);
    endfunction


    // set bits, used to see how many second level ways are left
    function automatic int unsigned ones(input logic [15:0] v);
        ones = 0;
        for (int i = 0; i < 16; i++)
            ones += v[i];
    endfunction

    // one counter per way of each cache, restarted by the shared interval tick
    genvar g;
    generate
        for (g = 0; g < L1_WAYS; g++)
        begin : g_l1
            cwr_way_counter #(.THRESHOLD(THRESHOLD)) u_cnt (
                .clk(CLK),
                .reset_n(RESET_N),
                .err(L1_ERR[g] & ~state.l1_dis[g]),
                .interval_end(state.tick_end),
                .over(l1_over[g])
            );
        end
        // second level counters, same shape as the first level ones
        for (g = 0; g < L2_WAYS; g++)
        begin : g_l2
            cwr_way_counter #(.THRESHOLD(THRESHOLD)) u_cnt (
                .clk(CLK),
                .reset_n(RESET_N),
                .err(L2_ERR[g] & ~state.l2_dis[g]),
                .interval_end(state.tick_end),
                .over(l2_over[g])
            );
        end
    endgenerate

    // parity classification of translation lookups and direct port reads
    cwr_xlate_check u_xc (
        .clk(CLK),
        .reset_n(RESET_N),
        .look(XLATE_LOOK),
        .inval(XLATE_INVAL),
        .repair_a(XLATE_REPAIR_A),
        .repair_b(XLATE_REPAIR_B),
        .fatal(FATAL_ERR),
        .urg_data(xc_urg_d),
        .urg_instr(xc_urg_i),
        .lock(XLATE_LOCK)
    );

    // retirement sequencer; only one retirement runs at a time, later
    // threshold events are held in the pending masks, except those of a way retired or under work
    always_comb
    begin
        logic [15:0] pick;
        pick = '0;
        next_state = state;
        // pulses default to low every cycle
        next_state.restr = 1'b0;
        next_state.urg_err = 1'b0;
        next_state.tick_end = 1'b0;
        // interval timer
        if (state.tick >= 32'(INTERVAL_CYCLES - 1))
        begin
            next_state.tick = '0;
            next_state.tick_end = 1'b1;
        end
        else
            next_state.tick = state.tick + 32'h1;
        // a way already retired or under work is not queued again, else the
        // tail of its error burst would retire it a second time
        next_state.l1_pend = (state.l1_pend | l1_over) & ~state.l1_dis & ~state.l1_op;
        next_state.l2_pend = (state.l2_pend | l2_over) & ~state.l2_dis & ~state.l2_op;
        // urgent flags: set wins over a clear in the same cycle
        if (URGENT_CLEAR)
        begin
            next_state.urg_d = 1'b0;
            next_state.urg_i = 1'b0;
        end
        if (xc_urg_d)
            next_state.urg_d = 1'b1;
        if (xc_urg_i)
            next_state.urg_i = 1'b1;
        // one urgent error pulse even when both ports report in one cycle
        if (xc_urg_d || xc_urg_i)
            next_state.urg_err = 1'b1;
        // degrade flags: a retirement in the same cycle wins over the clear
        if (ASYNC_FAULT_CLEAR)
        begin
            next_state.l1_dg = 1'b0;
            next_state.l2_dg = 1'b0;
        end
        // sequencer proper
        case (state.fsm)
            ST_IDLE:
            begin
                // first level work goes first; the second level may sit under hold
                if (state.l1_pend != '0)
                begin
                    // the lowest pending way is retired first
                    pick = first_one(16'(state.l1_pend));
                    next_state.src = CWR_SRC_L1;
                    next_state.l1_op = pick[L1_WAYS-1:0];
                    next_state.l1_pend = next_state.l1_pend & ~pick[L1_WAYS-1:0];
                    if (state.l1_dis != '0)
                        next_state.fsm = ST_L1_ENTRY;
                    else
                        next_state.fsm = ST_L1_WAY;
                end
                else if (state.l2_pend != '0)
                    next_state.fsm = ST_L2_WAIT;
            end
            ST_L1_ENTRY:
            begin
                // entry writeback then invalidate, done by the pipeline
                if (OP_DONE)
                    next_state.fsm = ST_DONE;
            end
            ST_L1_WAY:
            begin
                // dirty lines written back before the way is invalidated
                if (OP_DONE)
                begin
                    next_state.l1_dis = state.l1_dis | state.l1_op;
                    next_state.l1_dg = 1'b1;
                    next_state.restr = 1'b1;
                    next_state.fsm = ST_DONE;
                end
            end
            ST_L2_WAIT:
            begin
                // hold keeps the reduction pending without dropping it
                if (!L2_REDUCTION_HOLD)
                begin
                    pick = first_one(16'(state.l2_pend));
                    next_state.src = CWR_SRC_L2;
                    next_state.l2_op = pick[L2_WAYS-1:0];
                    next_state.l2_pend = next_state.l2_pend & ~pick[L2_WAYS-1:0];
                    // the way is kept when every other way is already retired
                    next_state.l2_keep = (ones(16'(state.l2_dis)) >= L2_WAYS - 1);
                    next_state.fsm = ST_L2_FLUSH;
                end
            end
            ST_L2_FLUSH:
            begin
                if (OP_DONE)
                begin
                    // a kept last way is flushed but stays in service
                    if (!state.l2_keep)
                        next_state.l2_dis = state.l2_dis | state.l2_op;
                    next_state.l2_dg = 1'b1;
                    next_state.restr = 1'b1;
                    next_state.fsm = ST_DONE;
                end
            end
            ST_DONE:
            begin
                // way selects drop one cycle after the flush request ends
                next_state.l1_op = '0;
                next_state.l2_op = '0;
                next_state.fsm = ST_IDLE;
            end
            // unused codes fall back to idle
            default:
                next_state.fsm = ST_IDLE;
        endcase
    end

    // synchronous reset puts every field to zero and the sequencer to idle
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            state <= '0;
            state.fsm <= ST_IDLE;
        end
        else
            state <= next_state;
    end

    // invalidate requests; the second level flush covers every way in both cases
    assign L1_ENTRY_FLUSH = (state.fsm == ST_L1_ENTRY);
    assign L1_WAY_FLUSH = (state.fsm == ST_L1_WAY);
    assign L2_FLUSH_ALL = (state.fsm == ST_L2_FLUSH);

    // way selects and retired masks straight from the state
    assign L1_OP_WAY = state.l1_op;
    assign L2_OP_WAY = state.l2_op;
    assign L1_WAY_DISABLE = state.l1_dis;
    assign L2_WAY_DISABLE = state.l2_dis;

    // sticky flags and one-cycle error pulses, all from flip-flops
    assign L1_WAY_DEGRADED_FLAG = state.l1_dg;
    assign L2_WAY_DEGRADED_FLAG = state.l2_dg;
    assign RESTRAINABLE_ERR = state.restr;
    assign DATA_XLATE_URGENT_FLAG = state.urg_d;
    assign INSTR_XLATE_URGENT_FLAG = state.urg_i;
    assign INSTR_URGENT_ERR = state.urg_err;
endmodule

// *** test/cwr_recovery_assertions.sv ***
// concurrent checks on the ports of the error recovery block
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module cwr_recovery_assertions
    import cwr_pkg::*;
#(
    parameter int L1_WAYS = 4,
    parameter int L2_WAYS = 8
)
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic L2_REDUCTION_HOLD,
    input cwr_xlate_s XLATE_LOOK,
    input wire logic L1_WAY_FLUSH,
    input wire logic L2_FLUSH_ALL,
    input wire logic [L1_WAYS-1:0] L1_WAY_DISABLE,
    input wire logic RESTRAINABLE_ERR,
    input wire logic DATA_XLATE_URGENT_FLAG,
    input wire logic INSTR_XLATE_URGENT_FLAG,
    input wire logic INSTR_URGENT_ERR,
    input wire logic FATAL_ERR,
    input wire logic XLATE_INVAL,
    input wire logic XLATE_REPAIR_A,
    input wire logic XLATE_REPAIR_B,
    input wire logic XLATE_LOCK
);
    logic maj;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // two of three lock copies decide, so one flipped copy is harmless
    assign maj = (XLATE_LOOK.lock_copies[0] & XLATE_LOOK.lock_copies[1]) |
        (XLATE_LOOK.lock_copies[0] & XLATE_LOOK.lock_copies[2]) | (XLATE_LOOK.lock_copies[1] & XLATE_LOOK.lock_copies[2]);
    sequence lookup_s;
        XLATE_LOOK.valid && !XLATE_LOOK.direct_port;
    endsequence
    sequence port_err_s;
        XLATE_LOOK.valid && XLATE_LOOK.direct_port && XLATE_LOOK.par_err_a;
    endsequence
    set_inval_a: assert property (lookup_s ##0 (!XLATE_LOOK.is_fully && XLATE_LOOK.par_err_a) |=> XLATE_INVAL)
        else $error("set associative entry not invalidated");
    copy_repair_a: assert property (lookup_s ##0 (XLATE_LOOK.is_fully && (XLATE_LOOK.par_err_a != XLATE_LOOK.par_err_b))
        |=> XLATE_REPAIR_A == $past(XLATE_LOOK.par_err_a) && XLATE_REPAIR_B == $past(XLATE_LOOK.par_err_b) && !FATAL_ERR)
        else $error("single copy error not repaired");
    both_copies_a: assert property (lookup_s ##0 (XLATE_LOOK.is_fully && XLATE_LOOK.par_err_a && XLATE_LOOK.par_err_b)
        |=> FATAL_ERR)
        else $error("double copy error not fatal");
    lock_vote_a: assert property (XLATE_LOOK.valid && XLATE_LOOK.is_fully |=> XLATE_LOCK == $past(maj))
        else $error("lock bit not the majority");
    data_urgent_a: assert property (port_err_s ##0 !XLATE_LOOK.is_instr |=> ##1 DATA_XLATE_URGENT_FLAG && INSTR_URGENT_ERR)
        else $error("data port error not urgent");
    instr_urgent_a: assert property (port_err_s ##0 XLATE_LOOK.is_instr |=> ##1 INSTR_XLATE_URGENT_FLAG && INSTR_URGENT_ERR)
        else $error("instruction port error not urgent");
    silent_lookup_a: assert property (lookup_s |=> ##1 !INSTR_URGENT_ERR)
        else $error("lookup error reported");
    hold_pending_a: assert property (L2_REDUCTION_HOLD [*3] |-> !$rose(L2_FLUSH_ALL))
        else $error("reduction started under hold");
    restr_cause_a: assert property (RESTRAINABLE_ERR |-> $past(L1_WAY_FLUSH) || $past(L2_FLUSH_ALL))
        else $error("restrainable error without way flush");
    disable_sticky_a: assert property (1'b1 |=> (L1_WAY_DISABLE & $past(L1_WAY_DISABLE)) == $past(L1_WAY_DISABLE))
        else $error("retired way came back");
endmodule

// *** test/cwr_pipe_model.sv ***
// far side model: pipeline and second level cache carrying out flushes
// assumes flush requests are levels held until done has been sampled
`timescale 1ns/1ps
module cwr_pipe_model
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic entry_flush,
    input wire logic way_flush,
    input wire logic flush_all,
    input wire logic slow,
    output logic done
);
    int cnt;
    logic sent;
    // one done pulse per request, after a short or a long walk over the lines
    always @(posedge clk)
    begin
        done <= 1'b0;
        if (!reset_n || !(entry_flush | way_flush | flush_all))
        begin
            cnt <= 0;
            sent <= 1'b0;
        end
        else if (!sent && cnt == (slow ? 20 : 2))
        begin
            done <= 1'b1;
            sent <= 1'b1;
        end
        else if (!sent)
            cnt <= cnt + 1;
    end
endmodule

// *** test/cwr_recovery_test.sv ***
// self-checking bench for the error recovery block with a flush partner
// assumes the package, the design and the partner are compiled before it
`timescale 1ns/1ps
module cwr_recovery_test;
    import cwr_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] l1_err = '0;
    logic [7:0] l2_err = '0;
    logic hold = 1'b0, af_clr = 1'b0, ug_clr = 1'b0, slow = 1'b0;
    cwr_xlate_s look = '0;
    logic op_done, l1_entry_flush, l1_way_flush, l2_flush_all, l1_flag, l2_flag, restr;
    logic dx_flag, ix_flag, urg_err, fatal, inval, rep_a, rep_b, lock;
    logic [3:0] l1_op_way, l1_dis;
    logic [7:0] l2_op_way, l2_dis;
    int error_cnt = 0;
    int comparisons = 0;
    int rcnt = 0;
    // short interval keeps the counter restart visible in a short run
    cwr_recovery #(.INTERVAL_CYCLES(64)) cwr_recovery_i (.CLK(clk), .RESET_N(reset_n), .L1_ERR(l1_err),
        .L2_ERR(l2_err), .L2_REDUCTION_HOLD(hold), .ASYNC_FAULT_CLEAR(af_clr), .URGENT_CLEAR(ug_clr),
        .XLATE_LOOK(look), .OP_DONE(op_done), .L1_ENTRY_FLUSH(l1_entry_flush), .L1_WAY_FLUSH(l1_way_flush),
        .L1_OP_WAY(l1_op_way), .L1_WAY_DISABLE(l1_dis), .L2_FLUSH_ALL(l2_flush_all), .L2_OP_WAY(l2_op_way),
        .L2_WAY_DISABLE(l2_dis), .L1_WAY_DEGRADED_FLAG(l1_flag), .L2_WAY_DEGRADED_FLAG(l2_flag),
        .RESTRAINABLE_ERR(restr), .DATA_XLATE_URGENT_FLAG(dx_flag), .INSTR_XLATE_URGENT_FLAG(ix_flag),
        .INSTR_URGENT_ERR(urg_err), .FATAL_ERR(fatal), .XLATE_INVAL(inval), .XLATE_REPAIR_A(rep_a),
        .XLATE_REPAIR_B(rep_b), .XLATE_LOCK(lock));
    cwr_pipe_model cwr_pipe_model_i (.clk(clk), .reset_n(reset_n), .entry_flush(l1_entry_flush),
        .way_flush(l1_way_flush), .flush_all(l2_flush_all), .slow(slow), .done(op_done));
    // 250 MHz core clock
    always #2 clk = ~clk;
    // restrainable errors are one-cycle pulses, so count them as they pass
    always @(posedge clk)
        if (restr === 1'b1)
            rcnt++;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // one lookup, its pulses one cycle later, urgent state one cycle after that
    task automatic xl(input logic i, f, d, a, b, input logic [2:0] lk, input logic [3:0] pul, input logic [2:0] urg);
        @(negedge clk);
        look = '{1'b1, i, f, d, 6'h15, a, b, lk};
        @(negedge clk);
        look = '0;
        chk("lookup pulses", {4'h0, pul}, {4'h0, inval, rep_a, rep_b, fatal});
        chk("lock vote", {7'h0, f & ((lk[0] & lk[1]) | (lk[0] & lk[2]) | (lk[1] & lk[2]))}, {7'h0, lock});
        @(negedge clk);
        chk("urgent state", {5'h0, urg}, {5'h0, dx_flag, ix_flag, urg_err});
        ug_clr = 1'b1;
        @(negedge clk);
        ug_clr = 1'b0;
    endtask
    // clear the degrade flags, then n back-to-back errors on one way
    task automatic errs(input logic l2, input int w, input int n);
        af_clr = 1'b1;
        @(negedge clk);
        af_clr = 1'b0;
        repeat (n)
        begin
            l1_err = l2 ? 4'h0 : 4'h1 << w;
            l2_err = l2 ? 8'h1 << w : 8'h0;
            @(negedge clk);
        end
        l1_err = '0;
        l2_err = '0;
    endtask
    // nine errors always leave five in one interval, whatever the timer phase
    task automatic finish(input logic l2, input int w, input logic entry, input logic kept);
        logic [7:0] dis0;
        logic [7:0] hot;
        int k;
        int r0;
        dis0 = l2 ? l2_dis : {4'h0, l1_dis};
        hot = 8'h1 << w;
        r0 = rcnt;
        k = 0;
        while ((l2 ? l2_flush_all : l1_way_flush | l1_entry_flush) !== 1'b1 && k < 300)
        begin
            @(negedge clk);
            k++;
        end
        chk("op way", hot, l2 ? l2_op_way : {4'h0, l1_op_way});
        if (!l2)
            chk("flush kind", {6'h0, entry, !entry}, {6'h0, l1_entry_flush, l1_way_flush});
        while ((l2_flush_all | l1_way_flush | l1_entry_flush) !== 1'b0 && k < 300)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 300)
        begin
            error_cnt++;
            $display("unexpected flush wait: expected end seen none");
            conclude();
        end
        repeat (2) @(negedge clk);
        chk("disabled ways", dis0 | (kept ? 8'h0 : hot), l2 ? l2_dis : {4'h0, l1_dis});
        chk("degrade flags", {6'h0, l2, !l2 & !entry}, {6'h0, l2_flag, l1_flag});
        chk("restrainable count", {7'h0, !entry}, 8'(rcnt - r0));
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        chk("reset outputs", 8'h0, {l1_flag, l2_flag, restr, fatal, inval, urg_err, l2_flush_all, l1_way_flush});
        reset_n = 1'b1;
        xl(0, 0, 0, 1, 0, 3'b111, 4'b1000, 3'b000);
        xl(0, 1, 0, 1, 0, 3'b011, 4'b0100, 3'b000);
        xl(0, 1, 0, 0, 1, 3'b001, 4'b0010, 3'b000);
        xl(0, 1, 0, 1, 1, 3'b110, 4'b0001, 3'b000);
        xl(0, 1, 0, 0, 0, 3'b101, 4'b0000, 3'b000);
        xl(0, 0, 1, 1, 0, 3'b000, 4'b0000, 3'b101);
        xl(1, 0, 1, 1, 0, 3'b000, 4'b0000, 3'b011);
        errs(0, 3, 4);
        repeat (70) @(negedge clk);
        errs(0, 3, 4);
        repeat (30) @(negedge clk);
        chk("retired ways", 8'h0, {4'h0, l1_dis});
        slow = 1'b1;
        errs(0, 0, 9);
        finish(0, 0, 0, 0);
        slow = 1'b0;
        errs(0, 1, 9);
        finish(0, 1, 1, 1);
        hold = 1'b1;
        errs(1, 5, 9);
        repeat (30) @(negedge clk);
        chk("held reduction", 8'h0, {7'h0, l2_flush_all});
        hold = 1'b0;
        finish(1, 5, 0, 0);
        for (int w = 0; w < 7; w++)
        begin
            if (w != 5)
            begin
                errs(1, w, 9);
                finish(1, w, 0, 0);
            end
        end
        errs(1, 7, 9);
        finish(1, 7, 0, 1);
        conclude();
    end
endmodule
bind cwr_recovery cwr_recovery_assertions #(.L1_WAYS(L1_WAYS), .L2_WAYS(L2_WAYS)) cwr_recovery_assertions_i (
    .CLK(CLK), .RESET_N(RESET_N), .L2_REDUCTION_HOLD(L2_REDUCTION_HOLD), .XLATE_LOOK(XLATE_LOOK),
    .L1_WAY_FLUSH(L1_WAY_FLUSH), .L2_FLUSH_ALL(L2_FLUSH_ALL), .L1_WAY_DISABLE(L1_WAY_DISABLE),
    .RESTRAINABLE_ERR(RESTRAINABLE_ERR), .DATA_XLATE_URGENT_FLAG(DATA_XLATE_URGENT_FLAG),
    .INSTR_XLATE_URGENT_FLAG(INSTR_XLATE_URGENT_FLAG), .INSTR_URGENT_ERR(INSTR_URGENT_ERR), .FATAL_ERR(FATAL_ERR),
    .XLATE_INVAL(XLATE_INVAL), .XLATE_REPAIR_A(XLATE_REPAIR_A), .XLATE_REPAIR_B(XLATE_REPAIR_B),
    .XLATE_LOCK(XLATE_LOCK));
